// ===== design/acr_pkg.sv
package acr_pkg;
   // Register index (printed offsets)
   localparam logic [11:0] REG_POWER_MODE = 12'h008;
   localparam logic [11:0] REG_ENHANCE = 12'h00C;
   localparam logic [11:0] REG_OUT_MODE = 12'h014;
   localparam logic [11:0] REG_CLK_PHASE = 12'h016;
   localparam logic [11:0] REG_SERIALIZER = 12'h021;
   localparam logic [11:0] REG_SERIAL_PIN = 12'h101;
   localparam logic [11:0] REG_COMMON_MODE = 12'h102;
   localparam logic [11:0] REG_CAL_STATUS = 12'h107;
   localparam logic [11:0] REG_GLITCH_REC = 12'h112;
   // Reset values
   localparam logic [7:0] RST_POWER_MODE = 8'h00;
   localparam logic [7:0] RST_ENHANCE = 8'h00;
   localparam logic [7:0] RST_OUT_MODE = 8'h01;
   localparam logic [7:0] RST_CLK_PHASE = 8'h03;
   localparam logic [7:0] RST_SERIALIZER = 8'h30;
   localparam logic [7:0] RST_SERIAL_PIN = 8'h00;
   localparam logic [7:0] RST_COMMON_MODE = 8'h00;
   localparam logic [7:0] RST_GLITCH_REC = 8'h07;
   // Power modes
   localparam logic [1:0] PM_NORMAL = 2'h0;
   localparam logic [1:0] PM_POWERDOWN = 2'h1;
   localparam logic [1:0] PM_STANDBY = 2'h2;
   localparam logic [1:0] PM_DIGRESET = 2'h3;
   // Field positions
   localparam int CHOP_BIT = 2;
   localparam int REDUCED_BIT = 6;
   localparam int INVERT_BIT = 2;
   localparam int TWOS_BIT = 0;
   localparam int SER_MODE_LSB = 4;
   localparam int REC_MODE_LSB = 3;
   localparam logic [2:0] REC_ON = 3'h5;
   localparam logic [2:0] REC_OFF = 3'h0;
   localparam logic [2:0] REC_SETUP_OK = 3'h7;
   // Serializer modes
   localparam logic [2:0] SER_SDR2_BIT = 3'h0;
   localparam logic [2:0] SER_SDR2_BYTE = 3'h1;
   localparam logic [2:0] SER_DDR2_A = 3'h2;
   localparam logic [2:0] SER_DDR2_B = 3'h3;
   localparam logic [2:0] SER_DDR1_WORD = 3'h4;
   localparam logic [3:0] MULT_DDR2 = 4'h4;
   localparam logic [3:0] MULT_X8 = 4'h8;
   localparam logic [3:0] PHASE_MAX_CODE = 4'hB;
   localparam logic [9:0] PHASE_STEP_DEG = 10'd60;
   // Timing
   localparam int RECOVERY_CYCLES = 31000000;
   localparam int CAL_CYCLES = 1024;
   // Controller registers (AHB byte addresses)
   localparam logic [7:0] CTL_ADDR = 8'h00;
   localparam logic [7:0] CTL_WDATA = 8'h04;
   localparam logic [7:0] CTL_CMD = 8'h08;
   localparam logic [7:0] CTL_STATUS = 8'h0C;
   localparam logic [7:0] CTL_RDATA = 8'h10;
   localparam logic [31:0] OKAY_READ_ZERO = 32'h0000_0000;
endpackage

// ===== design/acr_if.sv
`timescale 1ns/1ps
// Register port between controller and device
interface acr_if;
   logic req;
   logic we;
   logic [11:0] addr;
   logic [7:0] wdata;
   logic ack;
   logic [7:0] rdata;
   modport host (output req, output we, output addr, output wdata, input ack, input rdata);
   modport dev (input req, input we, input addr, input wdata, output ack, output rdata);
endinterface

// ===== design/acr_phase_decode.sv
`timescale 1ns/1ps
// Output clock phase and multiplier decode
module acr_phase_decode
   import acr_pkg::*;
(
   input wire logic [3:0] phase_code_i,
   input wire logic [2:0] ser_mode_i,
   output logic [9:0] phase_deg_o,
   output logic [3:0] clk_mult_o,
   output logic mode_valid_o
);
   logic [3:0] code_sat;
   // [RQ14] saturate at 660
   assign code_sat = (phase_code_i >= PHASE_MAX_CODE) ? PHASE_MAX_CODE : phase_code_i;
   assign phase_deg_o = 10'(code_sat * PHASE_STEP_DEG);
   // [RQ20] serializer decode
   always_comb begin
      clk_mult_o = MULT_X8;
      mode_valid_o = 1'b1;
      unique case (ser_mode_i)
         SER_SDR2_BIT, SER_SDR2_BYTE: clk_mult_o = MULT_X8;
         // [RQ21] double rate two lane
         SER_DDR2_A, SER_DDR2_B: clk_mult_o = MULT_DDR2;
         SER_DDR1_WORD: clk_mult_o = MULT_X8;
         default: mode_valid_o = 1'b0;
      endcase
   end
endmodule

// ===== design/acr_device.sv
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
// What this block does
// [RQ1] Mode 00: channels and datapath active
// [RQ2] Mode 01: gate clocks, reset datapath, outputs off
// [RQ3] Mode 10: gate clocks, outputs off, no reset
// [RQ4] Host avoids standby during calibration
// [RQ5] Calibrate at power-up and digital reset
// [RQ6] Mode 11: calibrate, reset datapath, not port
// [RQ7] Register port never reset by modes
// [RQ8] Enhancement bit 2 enables chopping
// [RQ9] Output bit 6 selects reduced range
// [RQ10] Output bit 2 inverts serial stream
// [RQ11] Output bit 0 twos complement default
// [RQ12] Input phase delays sampling 0..7 cycles
// [RQ13] Host keeps phase within divider ratio
// [RQ14] Output clock phase in 60 degree steps
// [RQ15] System keeps SDR rate within limit
// [RQ16] Recovery 000: stay disrupted until reset
// [RQ17] Recovery 101: recover after 31M cycles
// [RQ18] Recovery setup resets to 111
// [RQ19] Host writes 03 then 00 to reset
// [RQ20] Serializer mode field decode
// [RQ21] Output clock 4x or 8x sample rate
// [RQ22] All registers default at power-on reset
module acr_device
   import acr_pkg::*;
#(
   parameter int RECOVERY_COUNT = RECOVERY_CYCLES,
   parameter int CAL_COUNT = CAL_CYCLES
)(
   input wire logic CLOCK_I,
   input wire logic RESETN_I,
   acr_if.dev BUS,
   input wire logic GLITCH_I,
   input wire logic CLKDIV_ACTIVE_I,
   input wire logic [15:0] SAMPLE_A_I,
   input wire logic [15:0] SAMPLE_B_I,
   output logic DATAPATH_CLK_EN_O,
   output logic DATAPATH_RESET_O,
   output logic OUTPUT_EN_O,
   output logic CAL_BUSY_O,
   output logic CHOP_EN_O,
   output logic REDUCED_RANGE_O,
   output logic [2:0] SAMPLE_DELAY_O,
   output logic [9:0] DATA_OUTPUT_CLOCK_PHASE_O,
   output logic [3:0] DATA_OUTPUT_CLOCK_MULT_O,
   output logic [2:0] SERIAL_MODE_O,
   output logic [1:0] SERIAL_WORD_WIDTH_O,
   output logic DISRUPTED_O,
   output logic [15:0] LANE_A_O,
   output logic [15:0] LANE_B_O
);
   logic [7:0] power_mode, enhance, out_mode, clk_phase, serializer;
   logic [7:0] serial_pin, common_mode, glitch_rec;
   logic [1:0] cal_status;
   logic [$clog2(CAL_COUNT+1)-1:0] cal_cnt;
   logic [$clog2(RECOVERY_COUNT+1)-1:0] rec_cnt;
   logic disrupted, wr, mode_valid;
   logic [1:0] pm;
   logic dp_run;

   assign wr = BUS.req & BUS.we;
   assign pm = power_mode[1:0];

   ////////////////////////////////////////////////////////////////////////
   // Register writes, only power-on reset clears them
   // [RQ7] port untouched by modes
   // [RQ22] defaults at reset
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         power_mode <= RST_POWER_MODE;
         enhance <= RST_ENHANCE;
         out_mode <= RST_OUT_MODE;
         clk_phase <= RST_CLK_PHASE;
         serializer <= RST_SERIALIZER;
         serial_pin <= RST_SERIAL_PIN;
         common_mode <= RST_COMMON_MODE;
         // [RQ18] setup field 111
         glitch_rec <= RST_GLITCH_REC;
      end else if (wr) begin
         unique case (BUS.addr)
            REG_POWER_MODE: power_mode <= {6'h00, BUS.wdata[1:0]};
            REG_ENHANCE: enhance <= {5'h00, BUS.wdata[2], 2'h0};
            REG_OUT_MODE: out_mode <= {1'b0, BUS.wdata[6], 3'h0, BUS.wdata[2], 1'b0,
                                       BUS.wdata[0]};
            REG_CLK_PHASE: clk_phase <= {1'b0, BUS.wdata[6:0]};
            REG_SERIALIZER: serializer <= BUS.wdata;
            REG_SERIAL_PIN: serial_pin <= {7'h00, BUS.wdata[0]};
            REG_COMMON_MODE: common_mode <= {4'h0, BUS.wdata[3], 3'h0};
            REG_GLITCH_REC: glitch_rec <= {2'h0, BUS.wdata[5:0]};
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read path and one-cycle acknowledge
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         BUS.ack <= 1'b0;
         BUS.rdata <= 8'h00;
      end else begin
         BUS.ack <= BUS.req & ~BUS.ack;
         unique case (BUS.addr)
            REG_POWER_MODE: BUS.rdata <= power_mode;
            REG_ENHANCE: BUS.rdata <= enhance;
            REG_OUT_MODE: BUS.rdata <= out_mode;
            REG_CLK_PHASE: BUS.rdata <= clk_phase;
            REG_SERIALIZER: BUS.rdata <= serializer;
            REG_SERIAL_PIN: BUS.rdata <= serial_pin;
            REG_COMMON_MODE: BUS.rdata <= common_mode;
            // [RQ5] 0x00 means calibration done
            REG_CAL_STATUS: BUS.rdata <= {6'h00, cal_status};
            REG_GLITCH_REC: BUS.rdata <= glitch_rec;
            default: BUS.rdata <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Foreground calibration timer
   // [RQ5] start at power-up
   // [RQ6] restart during digital reset
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         cal_cnt <= '0;
         cal_status <= 2'h3;
      end else if (pm == PM_DIGRESET) begin
         cal_cnt <= '0;
         cal_status <= 2'h3;
      end else if (cal_status != 2'h0) begin
         if (cal_cnt == ($bits(cal_cnt))'(CAL_COUNT - 1)) begin
            cal_status <= 2'h0;
         end else begin
            cal_cnt <= cal_cnt + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Clock glitch disruption and recovery
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         disrupted <= 1'b0;
         rec_cnt <= '0;
      // A glitch seen during a digital reset still marks the part disrupted
      end else if (GLITCH_I) begin
         disrupted <= 1'b1;
         rec_cnt <= '0;
      end else if (pm == PM_DIGRESET) begin
         disrupted <= 1'b0;
         rec_cnt <= '0;
      // [RQ17] auto recovery count
      end else if (disrupted && glitch_rec[5:3] == REC_ON) begin
         if (rec_cnt == ($bits(rec_cnt))'(RECOVERY_COUNT - 1)) begin
            disrupted <= 1'b0;
            rec_cnt <= '0;
         end else begin
            rec_cnt <= rec_cnt + 1'b1;
         end
      end
      // [RQ16] otherwise stays disrupted
   end

   ////////////////////////////////////////////////////////////////////////
   // Power mode controls
   // [RQ1] [RQ2] [RQ3] [RQ6] mode gating
   assign dp_run = (pm == PM_NORMAL);
   assign DATAPATH_CLK_EN_O = dp_run;
   assign DATAPATH_RESET_O = (pm == PM_POWERDOWN) | (pm == PM_DIGRESET);
   assign OUTPUT_EN_O = dp_run & ~disrupted;
   assign CAL_BUSY_O = |cal_status;
   // [RQ8] chop enable
   assign CHOP_EN_O = enhance[CHOP_BIT];
   // [RQ9] reduced range swing
   assign REDUCED_RANGE_O = out_mode[REDUCED_BIT];
   // [RQ12] sampling delay only with divider
   assign SAMPLE_DELAY_O = CLKDIV_ACTIVE_I ? clk_phase[6:4] : 3'h0;
   assign SERIAL_MODE_O = serializer[SER_MODE_LSB +: 3];
   assign SERIAL_WORD_WIDTH_O = serializer[1:0];
   assign DISRUPTED_O = disrupted;

   // Phase in degrees and lane clock multiple from the live registers
   acr_phase_decode u_phase (
      .phase_code_i(clk_phase[3:0]),
      .ser_mode_i(serializer[SER_MODE_LSB +: 3]),
      .phase_deg_o(DATA_OUTPUT_CLOCK_PHASE_O),
      .clk_mult_o(DATA_OUTPUT_CLOCK_MULT_O),
      .mode_valid_o(mode_valid)
   );

   ////////////////////////////////////////////////////////////////////////
   // Output encoding of lane data
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I || DATAPATH_RESET_O) begin
         LANE_A_O <= 16'h0000;
         LANE_B_O <= 16'h0000;
      // Lanes freeze on an undefined serializer code
      end else if (dp_run && mode_valid) begin
         // [RQ11] offset binary flips the sign bit
         // [RQ10] invert whole stream
         LANE_A_O <= {SAMPLE_A_I[15] ^ ~out_mode[TWOS_BIT], SAMPLE_A_I[14:0]}
                     ^ {16{out_mode[INVERT_BIT]}};
         LANE_B_O <= {SAMPLE_B_I[15] ^ ~out_mode[TWOS_BIT], SAMPLE_B_I[14:0]}
                     ^ {16{out_mode[INVERT_BIT]}};
      end
   end
endmodule

// ===== design/acr_host.sv
`timescale 1ns/1ps
// AHB-Lite controller that drives the register port
module acr_host
   import acr_pkg::*;
(
   input wire logic CLOCK_I,
   input wire logic RESETN_I,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   acr_if.host PORT
);
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_BUSY = 2'b10} acr_state_t;
   acr_state_t state;
   logic [11:0] addr;
   logic [7:0] wdata, rdata;
   logic we, done, ph_wr;
   logic [7:0] ph_addr;

   assign HRESP_O = 1'b0;
   assign HREADYOUT_O = 1'b1;

   ////////////////////////////////////////////////////////////////////////
   // Address phase capture
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         ph_wr <= 1'b0;
         ph_addr <= 8'h00;
      end else begin
         ph_wr <= HSEL_I & HREADY_I & HTRANS_I[1] & HWRITE_I;
         ph_addr <= HADDR_I[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control registers written in data phase
   // [RQ4] [RQ13] [RQ19] sequencing left to software
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         addr <= 12'h000;
         wdata <= 8'h00;
         we <= 1'b0;
      // Writes dropped while a port transfer runs, so the request holds still
      end else if (ph_wr && state != ST_BUSY) begin
         unique case (ph_addr)
            CTL_ADDR: addr <= HWDATA_I[11:0];
            CTL_WDATA: wdata <= HWDATA_I[7:0];
            CTL_CMD: we <= HWDATA_I[0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Port transfer sequencer, set wins over clear of done
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         state <= ST_IDLE;
         done <= 1'b0;
         rdata <= 8'h00;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (ph_wr && ph_addr == CTL_CMD) begin
                  state <= ST_BUSY;
                  done <= 1'b0;
               end
            end
            ST_BUSY: begin
               if (PORT.ack) begin
                  state <= ST_IDLE;
                  done <= 1'b1;
                  rdata <= PORT.rdata;
               end
            end
         endcase
      end
   end

   assign PORT.req = (state == ST_BUSY) & ~PORT.ack;
   assign PORT.we = we;
   assign PORT.addr = addr;
   assign PORT.wdata = wdata;

   ////////////////////////////////////////////////////////////////////////
   // Read data mux
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         HRDATA_O <= OKAY_READ_ZERO;
      end else begin
         unique case (HADDR_I[7:0])
            CTL_ADDR: HRDATA_O <= {20'h00000, addr};
            CTL_WDATA: HRDATA_O <= {24'h000000, wdata};
            CTL_CMD: HRDATA_O <= {31'h00000000, we};
            CTL_STATUS: HRDATA_O <= {30'h00000000, done, state == ST_BUSY};
            CTL_RDATA: HRDATA_O <= {24'h000000, rdata};
            default: HRDATA_O <= OKAY_READ_ZERO;
         endcase
      end
   end
endmodule

// ===== tb/acr_port_monitor.sv
`timescale 1ns/1ps
// Watches the register port between controller and device
module acr_port_monitor
   import acr_pkg::*;
(
   input wire logic CLOCK_I,
   input wire logic RESETN_I,
   input wire logic req_i,
   input wire logic we_i,
   input wire logic [11:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic ack_i,
   input wire logic [7:0] rdata_i
);
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RESETN_I);
   ////////////////////////////////////////////////////////////////
   // Handshake
   a_ack_single: assert property (ack_i |=> !ack_i)
      else $error("ack held longer than one cycle");
   a_ack_cause: assert property (ack_i |-> $past(req_i))
      else $error("ack without a request");
   a_req_answered: assert property (req_i && !ack_i |=> ack_i)
      else $error("request not answered next cycle");
   a_req_held: assert property (req_i && !ack_i
      |=> $stable(addr_i) && $stable(we_i) && $stable(wdata_i))
      else $error("request changed before ack");
   ////////////////////////////////////////////////////////////////
   // Fixed and open fields read back as zero
   a_power_open: assert property (req_i && !ack_i && !we_i
      && addr_i == REG_POWER_MODE |=> rdata_i[7:2] == 6'h00)
      else $error("power mode open bits not zero");
   a_enh_open: assert property (req_i && !ack_i && !we_i
      && addr_i == REG_ENHANCE |=> rdata_i[7:3] == 5'h00 && rdata_i[1:0] == 2'h0)
      else $error("enhancement open bits not zero");
   a_out_fixed: assert property (req_i && !ack_i && !we_i
      && addr_i == REG_OUT_MODE
      |=> rdata_i[7] == 1'b0 && rdata_i[5:3] == 3'h0 && rdata_i[1] == 1'b0)
      else $error("output mode fixed bits not zero");
   a_rec_fixed: assert property (req_i && !ack_i && !we_i
      && addr_i == REG_GLITCH_REC |=> rdata_i[7:6] == 2'h0)
      else $error("recovery control high bits not zero");
   a_cal_open: assert property (req_i && !ack_i && !we_i
      && addr_i == REG_CAL_STATUS |=> rdata_i[7:2] == 6'h00)
      else $error("calibration status open bits not zero");
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
// Controller and device joined over the register port
module tb_top
   import acr_pkg::*;
;
   typedef struct packed {logic [11:0] a; logic [7:0] rst; logic [7:0] w; logic [7:0] r;} acr_row_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hready, hresp;
   logic glitch = 1'b0;
   logic clkdiv = 1'b1;
   logic [15:0] smp_a = 16'h1234;
   logic [15:0] smp_b = 16'h8001;
   logic clk_en, dp_rst, out_en, cal_busy, chop, reduced, disrupted;
   logic [2:0] delay, smode;
   logic [9:0] phase;
   logic [3:0] mult;
   logic [1:0] width;
   logic [15:0] lane_a, lane_b;
   logic [7:0] q;
   int err_total = 0;
   int comparisons = 0;
   acr_row_t rows [9] = '{
      '{REG_POWER_MODE, 8'h00, 8'hFC, 8'h00}, '{REG_ENHANCE, 8'h00, 8'hFF, 8'h04},
      '{REG_OUT_MODE, 8'h01, 8'hFF, 8'h45}, '{REG_CLK_PHASE, 8'h03, 8'hFF, 8'h7F},
      '{REG_SERIALIZER, 8'h30, 8'h40, 8'h40}, '{REG_SERIAL_PIN, 8'h00, 8'hFF, 8'h01},
      '{REG_COMMON_MODE, 8'h00, 8'hFF, 8'h08}, '{REG_GLITCH_REC, 8'h07, 8'hFF, 8'h3F},
      '{12'h0FF, 8'h00, 8'h55, 8'h00}};
   logic [7:0] om [5] = '{8'h01, 8'h00, 8'h05, 8'h04, 8'h41};
   logic [31:0] ex [5] = '{32'h1234_8001, 32'h9234_0001, 32'hEDCB_7FFE, 32'h6DCB_FFFE,
      32'h1234_8001};

   // 200 MHz clock
   always #2.5 clk = ~clk;

   acr_if acr_if_inst ();
   acr_host acr_host_inst (.CLOCK_I(clk), .RESETN_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
      .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
      .PORT(acr_if_inst));
   acr_device #(.RECOVERY_COUNT(20), .CAL_COUNT(8)) acr_device_inst (.CLOCK_I(clk),
      .RESETN_I(rst_n), .BUS(acr_if_inst), .GLITCH_I(glitch), .CLKDIV_ACTIVE_I(clkdiv),
      .SAMPLE_A_I(smp_a), .SAMPLE_B_I(smp_b), .DATAPATH_CLK_EN_O(clk_en),
      .DATAPATH_RESET_O(dp_rst), .OUTPUT_EN_O(out_en), .CAL_BUSY_O(cal_busy),
      .CHOP_EN_O(chop), .REDUCED_RANGE_O(reduced), .SAMPLE_DELAY_O(delay),
      .DATA_OUTPUT_CLOCK_PHASE_O(phase), .DATA_OUTPUT_CLOCK_MULT_O(mult),
      .SERIAL_MODE_O(smode), .SERIAL_WORD_WIDTH_O(width), .DISRUPTED_O(disrupted),
      .LANE_A_O(lane_a), .LANE_B_O(lane_b));
   acr_port_monitor acr_port_monitor_inst (.CLOCK_I(clk), .RESETN_I(rst_n),
      .req_i(acr_if_inst.req), .we_i(acr_if_inst.we), .addr_i(acr_if_inst.addr),
      .wdata_i(acr_if_inst.wdata), .ack_i(acr_if_inst.ack), .rdata_i(acr_if_inst.rdata));

   ////////////////////////////////////////////////////////////////
   // Comparison and verdict
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // One single word transfer, no wait count assumed
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
         output logic [31:0] rdv);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rdv = hrdata;
   endtask
   // Device register access through the controller
   task automatic dev(input logic wr, input logic [11:0] a, input logic [7:0] d,
         output logic [7:0] rv);
      logic [31:0] s;
      ahb(1'b1, CTL_ADDR, {20'h0, a}, s);
      ahb(1'b1, CTL_WDATA, {24'h0, d}, s);
      ahb(1'b1, CTL_CMD, {31'h0, wr}, s);
      do ahb(1'b0, CTL_STATUS, 32'h0, s); while (s[0] !== 1'b0);
      ahb(1'b0, CTL_RDATA, 32'h0, s);
      rv = s[7:0];
      #1;
   endtask
   task automatic pulse_glitch();
      @(posedge clk);
      glitch <= 1'b1;
      @(posedge clk);
      glitch <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1 chk(32'(cal_busy), 32'h1);
      chk(32'(phase), 32'd180);
      chk(32'(mult), 32'h4);
      chk({lane_a, lane_b}, 32'h1234_8001);
      chk(32'({clk_en, dp_rst, out_en}), 32'h5);
      chk(32'(hresp), 32'h0);
      foreach (rows[i]) begin
         dev(1'b0, rows[i].a, 8'h00, q);
         chk(32'(q), 32'(rows[i].rst));
         dev(1'b1, rows[i].a, rows[i].w, q);
         dev(1'b0, rows[i].a, 8'h00, q);
         chk(32'(q), 32'(rows[i].r));
      end
      dev(1'b0, REG_CAL_STATUS, 8'h00, q);
      chk(32'(q), 32'h0);
      chk(32'(chop), 32'h1);
      // divider ratio taken as 7, so every phase code is legal
      for (int c = 0; c < 16; c++) begin
         dev(1'b1, REG_CLK_PHASE, {1'b0, c[2:0], c[3:0]}, q);
         chk(32'(phase), 32'((c > 10 ? 11 : c) * 60));
         chk(32'(delay), 32'(c[2:0]));
      end
      @(posedge clk);
      clkdiv <= 1'b0;
      @(posedge clk);
      #1 chk(32'(delay), 32'h0);
      // no sample rate here, so every serializer mode is allowed
      for (int m = 0; m < 5; m++) begin
         dev(1'b1, REG_SERIALIZER, {1'b0, m[2:0], 4'h0}, q);
         chk(32'(smode), 32'(m));
         chk(32'(mult), (m == 2 || m == 3) ? 32'h4 : 32'h8);
         chk(32'(width), 32'h0);
      end
      for (int i = 0; i < 5; i++) begin
         dev(1'b1, REG_OUT_MODE, om[i], q);
         repeat (2) @(posedge clk);
         #1 chk({lane_a, lane_b}, ex[i]);
         chk(32'(reduced), 32'(om[i][6]));
      end
      dev(1'b1, REG_ENHANCE, 8'h00, q);
      chk(32'(chop), 32'h0);
      // standby only once calibration has finished
      dev(1'b1, REG_POWER_MODE, 8'h02, q);
      chk(32'({clk_en, dp_rst, out_en}), 32'h0);
      chk({lane_a, lane_b}, 32'h1234_8001);
      dev(1'b1, REG_POWER_MODE, 8'h01, q);
      chk(32'({clk_en, dp_rst, out_en}), 32'h2);
      chk({lane_a, lane_b}, 32'h0);
      dev(1'b1, REG_POWER_MODE, 8'h03, q);
      chk(32'({dp_rst, cal_busy}), 32'h3);
      dev(1'b0, REG_CAL_STATUS, 8'h00, q);
      chk(32'(q), 32'h3);
      dev(1'b0, REG_POWER_MODE, 8'h00, q);
      chk(32'(q), 32'h3);
      dev(1'b1, REG_POWER_MODE, 8'h00, q);
      chk(32'({clk_en, dp_rst, out_en}), 32'h5);
      dev(1'b0, REG_CAL_STATUS, 8'h00, q);
      chk(32'(q), 32'h0);
      // Glitch with recovery off, then with recovery on
      // setup field kept at 111 in both writes
      dev(1'b1, REG_GLITCH_REC, 8'h07, q);
      pulse_glitch();
      repeat (40) @(posedge clk);
      #1 chk(32'({disrupted, out_en}), 32'h2);
      dev(1'b1, REG_POWER_MODE, 8'h03, q);
      dev(1'b1, REG_POWER_MODE, 8'h00, q);
      chk(32'(disrupted), 32'h0);
      dev(1'b1, REG_GLITCH_REC, 8'h2F, q);
      pulse_glitch();
      repeat (5) @(posedge clk);
      #1 chk(32'(disrupted), 32'h1);
      repeat (25) @(posedge clk);
      #1 chk(32'(disrupted), 32'h0);
      // Mid-run reset restores defaults and restarts calibration
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1 chk(32'(cal_busy), 32'h1);
      dev(1'b0, REG_OUT_MODE, 8'h00, q);
      chk(32'(q), 32'h01);
      report_and_stop();
   end

   // Watchdog, far beyond the roughly 1300 cycles the tests need
   initial begin
      #200000;
      err_total++;
      report_and_stop();
   end
endmodule
